// ### logic/inc_dec_skip_branch_exec.sv
/*
  Execution unit for increment, decrement, their skip-if-zero forms,
  the unconditional jump, the configuration load and a literal load
  of the working register.
  Assumes program memory hands in the word fetched at the previous
  program counter, one word per cycle, registered on mclk.
*/
`timescale 1ns/10ps
`default_nettype none
module inc_dec_skip_branch_exec
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fetched instruction
  input wire logic [INSTR_W-1:0] instr,
  // File preload
  input wire logic load_we,
  input wire logic [FADDR_W-1:0] load_addr,
  input wire logic [DATA_W-1:0] load_data,
  // Core state
  output logic [PC_W-1:0] pc,
  output logic [DATA_W-1:0] work_reg,
  output logic discard_next,
  // Configuration register and its fields
  output logic [DATA_W-1:0] timer_wake_pullup_config,
  output logic pin_change_wake_disable,
  output logic weak_pullup_disable,
  output logic timer_clock_source,
  output logic timer_edge_select,
  output logic prescaler_assign,
  output logic [2:0] prescale_ratio,
  // Prescaler routing
  output logic prescaler_to_timer,
  output logic prescaler_to_watchdog
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [DATA_W-1:0] w;
    logic [DATA_W-1:0] cfg;
    // Set when the word now on instr must run as a no-op
    logic discard;
    logic to_timer;
    logic to_wdt;
  } exec_s;

  exec_s st_ff;
  exec_s nxt_st;

  file_bus_if fb ();

  file_store u_store (
    .mclk(mclk),
    .rst(rst),
    .load_we(load_we),
    .load_addr(load_addr),
    .load_data(load_data),
    .fb(fb)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Zero test shared by the flag update and both skip forms
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return (v == '0);
  endfunction

  // The four read-modify-write forms share destination routing
  function automatic logic is_arith(input op_e o);
    return (o == OP_DEC) || (o == OP_DECSKIP) || (o == OP_INC) || (o == OP_INCSKIP);
  endfunction

  // ----------------------------------------------------------------
  // Operands
  // ----------------------------------------------------------------
  op_e op;
  logic [DATA_W-1:0] result;
  logic to_file;

  // File read is combinational, so the operand is ready in the same cycle
  assign fb.rd_addr = instr[FADDR_W-1:0];
  assign to_file = instr[DEST_BIT];

  // ----------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------
  always_comb begin
    // Defaults: sequential fetch, no write, no flag change
    nxt_st = st_ff;
    nxt_st.pc = st_ff.pc + 11'h001;
    nxt_st.discard = 1'b0;
    fb.wr_en = 1'b0;
    fb.wr_addr = instr[FADDR_W-1:0];
    fb.wr_data = 8'h00;
    fb.z_en = 1'b0;
    fb.z_val = 1'b0;
    result = 8'h00;
    // A discarded word executes as a no-op
    op = st_ff.discard ? OP_IDLE : decode_op(instr);
    // Result only matters for the four arithmetic forms
    unique case (op)
      OP_DEC, OP_DECSKIP: begin
        result = fb.rd_data - 8'h01;
      end
      OP_INC, OP_INCSKIP: begin
        result = fb.rd_data + 8'h01;
      end
      default: begin
        result = 8'h00;
      end
    endcase

    // Skip forms never drive the zero-flag write port
    unique case (op)
      OP_DEC: begin
        fb.z_en = 1'b1;
        fb.z_val = is_zero(result);
      end
      OP_INC: begin
        fb.z_en = 1'b1;
        fb.z_val = is_zero(result);
      end
      OP_DECSKIP: begin
        nxt_st.discard = is_zero(result);
      end
      OP_INCSKIP: begin
        nxt_st.discard = is_zero(result);
      end
      OP_JUMP: begin
        // Page bits come from the status word as it stands now
        nxt_st.pc = {fb.page, instr[LIT9_HI:0]};
        // Stale prefetch dropped so the jump costs two cycles
        nxt_st.discard = 1'b1;
      end
      OP_CFGLOAD: begin
        // No file address, so this is the only way in
        nxt_st.cfg = st_ff.w;
      end
      OP_LOADW: begin
        // Lets software seed the working register
        nxt_st.w = instr[LIT8_HI:0];
      end
      default: begin
        nxt_st.discard = 1'b0;
      end
    endcase

    // Destination routing shared by all four arithmetic forms
    if (is_arith(op)) begin
      if (to_file) begin
        fb.wr_en = 1'b1;
        fb.wr_data = result;
      end else begin
        nxt_st.w = result;
      end
    end

    // Shared prescaler has exactly one owner at a time
    nxt_st.to_timer = ~nxt_st.cfg[CFG_ASSIGN_BIT];
    nxt_st.to_wdt = nxt_st.cfg[CFG_ASSIGN_BIT];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      // Counter wraps to zero on the first edge after release
      st_ff.pc <= PC_RESET;
      st_ff.w <= W_RESET;
      st_ff.cfg <= CFG_RESET;
      // Word on the bus at release is not a real fetch
      st_ff.discard <= 1'b1;
      // Matches the all-ones configuration: watchdog owns the prescaler
      st_ff.to_timer <= 1'b0;
      st_ff.to_wdt <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every port is a plain copy of a register field
  // Core state
  assign pc = st_ff.pc;
  assign work_reg = st_ff.w;
  assign discard_next = st_ff.discard;

  // Configuration fields
  assign timer_wake_pullup_config = st_ff.cfg;
  assign pin_change_wake_disable = st_ff.cfg[CFG_WAKE_BIT];
  assign weak_pullup_disable = st_ff.cfg[CFG_PULLUP_BIT];
  assign timer_clock_source = st_ff.cfg[CFG_TCS_BIT];
  assign timer_edge_select = st_ff.cfg[CFG_TSE_BIT];
  assign prescaler_assign = st_ff.cfg[CFG_ASSIGN_BIT];
  assign prescale_ratio = st_ff.cfg[CFG_RATIO_HI:CFG_RATIO_LO];

  // Prescaler routing
  assign prescaler_to_timer = st_ff.to_timer;
  assign prescaler_to_watchdog = st_ff.to_wdt;

endmodule // inc_dec_skip_branch_exec
`default_nettype wire

// ### logic/exec_pkg.sv
/*
  Shared constants, opcode patterns and decode helper for the
  increment/decrement/skip/branch execution block.
  Assumes a 12-bit instruction word and a 32-entry file space.
*/
`default_nettype none
package exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int INSTR_W = 12;
  localparam int PC_W = 11;
  localparam int FADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int FILE_DEPTH = 32;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET = 11'h7FF;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'hFF;
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Status register placement
  // ----------------------------------------------------------------
  localparam logic [FADDR_W-1:0] STATUS_IDX = 5'h03;
  localparam int STATUS_Z_BIT = 2;
  localparam int STATUS_PAGE_HI = 6;
  localparam int STATUS_PAGE_LO = 5;

  // ----------------------------------------------------------------
  // Configuration register fields
  // ----------------------------------------------------------------
  localparam int CFG_WAKE_BIT = 7;
  localparam int CFG_PULLUP_BIT = 6;
  localparam int CFG_TCS_BIT = 5;
  localparam int CFG_TSE_BIT = 4;
  localparam int CFG_ASSIGN_BIT = 3;
  localparam int CFG_RATIO_HI = 2;
  localparam int CFG_RATIO_LO = 0;

  // ----------------------------------------------------------------
  // Instruction fields and opcode patterns
  // ----------------------------------------------------------------
  localparam int DEST_BIT = 5;
  localparam int LIT9_HI = 8;
  localparam int LIT8_HI = 7;
  localparam logic [5:0] OPC_DEC = 6'h03;
  localparam logic [5:0] OPC_DECSKIP = 6'h0B;
  localparam logic [5:0] OPC_INC = 6'h0A;
  localparam logic [5:0] OPC_INCSKIP = 6'h0F;
  localparam logic [2:0] OPC_JUMP = 3'h5;
  localparam logic [3:0] OPC_LOADW = 4'hC;
  localparam logic [INSTR_W-1:0] OPC_CFGLOAD = 12'h002;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_DEC = 3'b001,
    OP_DECSKIP = 3'b010,
    OP_INC = 3'b011,
    OP_INCSKIP = 3'b100,
    OP_JUMP = 3'b101,
    OP_CFGLOAD = 3'b110,
    OP_LOADW = 3'b111
  } op_e;

  function automatic op_e decode_op(input logic [INSTR_W-1:0] ins);
    op_e op;
    op = OP_IDLE;
    if (ins[11:9] == OPC_JUMP) begin
      op = OP_JUMP;
    end else if (ins[11:8] == OPC_LOADW) begin
      op = OP_LOADW;
    end else if (ins == OPC_CFGLOAD) begin
      op = OP_CFGLOAD;
    end else if (ins[11:6] == OPC_DEC) begin
      op = OP_DEC;
    end else if (ins[11:6] == OPC_DECSKIP) begin
      op = OP_DECSKIP;
    end else if (ins[11:6] == OPC_INC) begin
      op = OP_INC;
    end else if (ins[11:6] == OPC_INCSKIP) begin
      op = OP_INCSKIP;
    end
    return op;
  endfunction

endpackage
`default_nettype wire

// ### logic/file_bus_if.sv
/*
  Carrier between the execution unit and its file store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface file_bus_if;
  import exec_pkg::*;
  logic [FADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic [1:0] page;
  logic wr_en;
  logic [FADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic z_en;
  logic z_val;

  modport exec (output rd_addr, input rd_data, input page, output wr_en, output wr_addr,
                output wr_data, output z_en, output z_val);
  modport store (input rd_addr, output rd_data, output page, input wr_en, input wr_addr,
                 input wr_data, input z_en, input z_val);
endinterface
`default_nettype wire

// ### logic/file_store.sv
/*
  Flip-flop file space with one combinational read port, one data
  write port, a zero-flag write port and a preload port.
  Assumes the reader tolerates an asynchronous read path.
*/
`timescale 1ns/10ps
`default_nettype none
module file_store
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Preload from outside
  input wire logic load_we,
  input wire logic [FADDR_W-1:0] load_addr,
  input wire logic [DATA_W-1:0] load_data,
  // Execution side
  file_bus_if.store fb
);

  typedef struct packed {
    logic [FILE_DEPTH-1:0][DATA_W-1:0] mem;
  } store_s;

  store_s st_ff;
  store_s nxt_st;

  assign fb.rd_data = st_ff.mem[fb.rd_addr];
  assign fb.page = st_ff.mem[STATUS_IDX][STATUS_PAGE_HI:STATUS_PAGE_LO];

  always_comb begin
    nxt_st = st_ff;
    if (fb.wr_en) begin
      nxt_st.mem[fb.wr_addr] = fb.wr_data;
    end
    // Flag write after the data write so it survives a result aimed at status; a preload to status still wins
    if (fb.z_en) begin
      nxt_st.mem[STATUS_IDX][STATUS_Z_BIT] = fb.z_val;
    end
    if (load_we) begin
      nxt_st.mem[load_addr] = load_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule // file_store
`default_nettype wire

// ### dv/exec_props.sv
/*
  Port checker for the execution block.
  Assumes one clock, synchronous active-high reset, bound below.
*/
`timescale 1ns/10ps
`default_nettype none
module exec_props
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction and core state
  input wire logic [INSTR_W-1:0] instr,
  input wire logic [PC_W-1:0] pc,
  input wire logic [DATA_W-1:0] work_reg,
  input wire logic discard_next,
  // Configuration
  input wire logic [DATA_W-1:0] timer_wake_pullup_config,
  input wire logic pin_change_wake_disable,
  input wire logic weak_pullup_disable,
  input wire logic timer_clock_source,
  input wire logic timer_edge_select,
  input wire logic prescaler_assign,
  input wire logic [2:0] prescale_ratio,
  input wire logic prescaler_to_timer,
  input wire logic prescaler_to_watchdog
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic live;
  logic [DATA_W-1:0] cfg;
  assign live = !discard_next;
  assign cfg = timer_wake_pullup_config;
  // ----------------
  // Assertions
  // ----------------
  cfg_reset_a: assert property ($past(rst) |-> cfg == CFG_RESET)
    else $error("config not all ones after reset");
  cfg_fields_a: assert property ({pin_change_wake_disable, weak_pullup_disable, timer_clock_source,
    timer_edge_select, prescaler_assign, prescale_ratio} == cfg) else $error("config fields misplaced");
  prescale_route_a: assert property (prescaler_to_watchdog == cfg[CFG_ASSIGN_BIT] &&
    prescaler_to_timer == !cfg[CFG_ASSIGN_BIT])
    else $error("prescaler routing wrong");
  cfg_hold_a: assert property (!(live && instr == OPC_CFGLOAD) |=> $stable(cfg))
    else $error("config changed without load");
  cfg_load_a: assert property (live && instr == OPC_CFGLOAD |=> cfg == $past(work_reg))
    else $error("config load wrong");
  jump_low_a: assert property (live && instr[11:9] == OPC_JUMP |=>
    pc[8:0] == $past(instr[8:0]) && discard_next) else $error("jump target wrong");
  pc_step_a: assert property (!live || instr[11:9] != OPC_JUMP |=> pc == $past(pc) + 11'h1)
    else $error("counter did not step");
  skip_w_a: assert property (live && !instr[DEST_BIT] && (instr[11:6] == OPC_DECSKIP ||
    instr[11:6] == OPC_INCSKIP) |=> discard_next == (work_reg == 8'h00)) else $error("skip wrong");
  plain_noskip_a: assert property (live && (instr[11:6] == OPC_DEC || instr[11:6] == OPC_INC)
    |=> !discard_next) else $error("plain op skipped");
  cover property (live && instr[11:9] == OPC_JUMP);
  cover property (live && instr[11:6] == OPC_DECSKIP ##1 discard_next);
  cover property (live && instr == OPC_CFGLOAD);
endmodule // exec_props
bind inc_dec_skip_branch_exec exec_props u_props (.mclk(mclk), .rst(rst), .instr(instr), .pc(pc),
  .work_reg(work_reg), .discard_next(discard_next), .timer_wake_pullup_config(timer_wake_pullup_config),
  .pin_change_wake_disable(pin_change_wake_disable), .weak_pullup_disable(weak_pullup_disable),
  .timer_clock_source(timer_clock_source), .timer_edge_select(timer_edge_select),
  .prescaler_assign(prescaler_assign), .prescale_ratio(prescale_ratio),
  .prescaler_to_timer(prescaler_to_timer), .prescaler_to_watchdog(prescaler_to_watchdog));
`default_nettype wire

// ### dv/inc_dec_skip_branch_exec_tb_top.sv
/*
  Self-checking bench with an integer model of the core.
  Assumes the bench hands in instructions directly at the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module inc_dec_skip_branch_exec_tb_top;
  import exec_pkg::*;
  logic mclk = 0, rst = 1, load_we = 0, discard_next, to_tmr, to_wdt;
  logic [11:0] instr = 0;
  logic [4:0] load_addr = 0;
  logic [7:0] load_data = 0, work_reg, cfg;
  logic f_wake, f_pull, f_src, f_edge, f_asg;
  logic [2:0] f_ratio;
  logic [10:0] pc;
  int miscompares = 0, check_count = 0, seed = 32'h4281;
  int mw, mpc, mcfg, mdis, k;
  int mf[32];
  logic [11:0] tbl[7] = '{12'h0C0, 12'h2C0, 12'h280, 12'h3C0, 12'hA00, 12'hC00, 12'h002};
  logic [11:0] msk[7] = '{12'h03F, 12'h03F, 12'h03F, 12'h03F, 12'h1FF, 12'h0FF, 12'h000};
  inc_dec_skip_branch_exec DUT (.mclk(mclk), .rst(rst), .instr(instr), .load_we(load_we),
    .load_addr(load_addr), .load_data(load_data), .pc(pc), .work_reg(work_reg),
    .discard_next(discard_next), .timer_wake_pullup_config(cfg), .pin_change_wake_disable(f_wake),
    .weak_pullup_disable(f_pull), .timer_clock_source(f_src), .timer_edge_select(f_edge),
    .prescaler_assign(f_asg), .prescale_ratio(f_ratio), .prescaler_to_timer(to_tmr),
    .prescaler_to_watchdog(to_wdt));
  initial forever #2 mclk = ~mclk;
  // ----------------
  // Check helpers
  // ----------------
  task automatic chk(string n, logic [10:0] got, int e);
    check_count++;
    if (got !== 11'(e)) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", n, e, got);
    end
  endtask
  task automatic compare_all();
    chk("pc", pc, mpc);
    chk("work_reg", {3'h0, work_reg}, mw);
    chk("discard", {10'h0, discard_next}, mdis);
    chk("config", {3'h0, cfg}, mcfg);
    chk("fields", {3'h0, f_wake, f_pull, f_src, f_edge, f_asg, f_ratio}, mcfg);
    chk("to_watchdog", {10'h0, to_wdt}, mcfg[3]);
    chk("to_timer", {10'h0, to_tmr}, !mcfg[3]);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset(int n);
    rst = 1;
    repeat (n) @(negedge mclk);
    foreach (mf[j]) mf[j] = 0;
    mw = 0;
    mpc = 2047;
    mcfg = 255;
    mdis = 1;
    compare_all();
    rst = 0;
  endtask
  // One instruction, optional preload in the same cycle
  task automatic step(logic [11:0] i, bit we = 0, int a = 0, int d = 0);
    int r, f;
    instr = i;
    load_we = we;
    load_addr = a[4:0];
    load_data = d[7:0];
    f = i[4:0];
    r = -1;
    if (mdis) begin
      mdis = 0;
      mpc++;
    end else if (i[11:9] == OPC_JUMP) begin
      mpc = {mf[3][6:5], i[8:0]};
      mdis = 1;
    end else begin
      mpc++;
      if (i[11:6] == OPC_DEC || i[11:6] == OPC_DECSKIP) r = (mf[f] - 1) & 255;
      if (i[11:6] == OPC_INC || i[11:6] == OPC_INCSKIP) r = (mf[f] + 1) & 255;
      if (r >= 0) begin
        if (i[DEST_BIT]) mf[f] = r;
        else mw = r;
        if (i[11:6] == OPC_DEC || i[11:6] == OPC_INC) mf[3] = (mf[3] & ~4) | (int'(r == 0) << 2);
        else mdis = (r == 0);
      end
      if (i[11:8] == OPC_LOADW) mw = i[7:0];
      if (i == OPC_CFGLOAD) mcfg = mw;
    end
    mpc &= 2047;
    if (we) mf[a] = d & 255;
    @(negedge mclk);
    compare_all();
  endtask
  // ----------------
  // Scenarios
  // ----------------
  initial begin
    do_reset(20);
    step(12'hC11, 1, 8, 1);
    step(12'hC5A);
    step(12'h002);
    step(12'hCA3);
    step(12'h002);
    step(12'h2C8, 1, 9, 255);
    step(12'hC11);
    step(12'h283);
    step(12'h3E9);
    step(12'hC22);
    step(12'h0E9, 1, 3, 8'h60);
    step(12'h283);
    step(12'h2A3);
    step(12'hB55);
    step(12'hC33);
    do_reset(3);
    repeat (400) begin
      k = {$random(seed)} % 7;
      step(tbl[k] | (msk[k] & 12'($random(seed))), $random(seed) & 1, {$random(seed)} % 32,
        {$random(seed)} % 256);
    end
    print_verdict();
  end
  initial begin
    #(4 * 2000);
    miscompares++;
    print_verdict();
  end
endmodule // inc_dec_skip_branch_exec_tb_top
`default_nettype wire
